// ==== rtl/mtc_consts.svh ====
// Timing counts and reset values for the measurement trigger control block.
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH
`define MTC_CLK_PERIOD_NS   100
`define MTC_DONE_PULSE_NS   10000
`define MTC_DONE_PULSE_CYC  ((`MTC_DONE_PULSE_NS + `MTC_CLK_PERIOD_NS - 1) / `MTC_CLK_PERIOD_NS)
`define MTC_CONV_CYCLES     64
`define MTC_TBASE_CYCLES    200
`define MTC_STORE_IVL_RST   8'h01
`define MTC_SYNC_ONES       3'h7
`define MTC_PIN_IDLE        1'b1
`endif

// ==== rtl/mtc_edge_sync.sv ====
// Three-stage synchroniser with falling-edge detector for the trigger pin.
`timescale 1ns/100ps
`include "mtc_consts.svh"
module mtc_edge_sync
  import mtc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic pin_in,
  output logic      fall_pulse
);
  logic [2:0] sync_r;
  logic       level_r;
  logic       fall_r;
  wire        agree     = (sync_r[2] == sync_r[1]);
  wire        level_nxt = agree ? sync_r[2] : level_r;
  wire        fall_nxt  = agree & level_r & ~sync_r[2];

  // Idle level is high because of the pull-up on the pin.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      sync_r <= `MTC_SYNC_ONES;
    else
      sync_r <= {sync_r[1:0], pin_in};
  end

  // A change counts once stages two and three agree on the new level.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      level_r <= `MTC_PIN_IDLE;
      fall_r  <= 1'b0;
    end
    else
    begin
      level_r <= level_nxt;
      fall_r  <= fall_nxt;
    end
  end

  assign fall_pulse = fall_r;

  one_pulse_per_edge_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) fall_pulse |=> !fall_pulse)
    else $error("Trigger edge produced more than one pulse.");
endmodule : mtc_edge_sync

// ==== rtl/mtc_pkg.sv ====
// Types for the measurement trigger control block.
package mtc_pkg;
  typedef enum logic [1:0]
  {
    MTC_MODE_CONT_INT,
    MTC_MODE_CONT_EXT,
    MTC_MODE_ONESHOT_EXT
  } mtc_mode_t;

  typedef enum logic [1:0]
  {
    MTC_ST_IDLE,
    MTC_ST_CONV,
    MTC_ST_DONE
  } mtc_state_t;
endpackage : mtc_pkg

// ==== rtl/mtc_trigger_ctrl.sv ====
// Trigger sequencing, reading start and completion pulse for the meter.
`timescale 1ns/100ps
`include "mtc_consts.svh"
module mtc_trigger_ctrl
  import mtc_pkg::*;
#(
  parameter int CONV_CYCLES  = `MTC_CONV_CYCLES,
  parameter int TBASE_CYCLES = `MTC_TBASE_CYCLES,
  parameter int IVL_W        = 8
)
(
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             ext_trig_n,
  input  wire logic             panel_trig,
  input  wire logic             mode_load,
  input  wire logic [1:0]       mode_sel,
  input  wire logic             store_en,
  input  wire logic [IVL_W-1:0] store_interval_cmd,
  output logic                  conv_start,
  output logic                  conv_busy,
  output logic                  store_wr,
  output logic                  complete_n,
  output logic                  armed,
  output logic [1:0]            mode_now
);
  localparam int DONE_CYC = `MTC_DONE_PULSE_CYC;
  localparam int CW       = $clog2(CONV_CYCLES + TBASE_CYCLES + DONE_CYC + 2);

  mtc_mode_t        mode_r;
  mtc_mode_t        mode_nxt;
  mtc_state_t       state_r;
  mtc_state_t       state_nxt;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             run_r;
  logic             run_nxt;
  logic             storing_r;
  logic             storing_nxt;
  logic [IVL_W-1:0] ivl_cnt_r;
  logic [IVL_W-1:0] ivl_cnt_nxt;
  logic             start_r;
  logic             busy_r;
  logic             wr_r;
  logic             done_n_r;
  logic             armed_r;
  logic             wr_nxt;
  logic             ext_fall;
  logic             pan_q;

  mtc_edge_sync u_sync
  (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .pin_in     (ext_trig_n),
    .fall_pulse (ext_fall)
  );

  // Panel press is already on this clock; take its rising edge.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      pan_q <= 1'b0;
    else
      pan_q <= panel_trig;
  end

  wire pan_rise  = panel_trig & ~pan_q;
  wire is_ext    = (mode_r != MTC_MODE_CONT_INT);
  wire is_oneshot = (mode_r == MTC_MODE_ONESHOT_EXT);
  wire trig_evt  = is_ext & (ext_fall | pan_rise);
  wire conv_end  = (state_r == MTC_ST_CONV) &&
                   (cnt_r == CW'(CONV_CYCLES - 1));
  wire done_end  = (state_r == MTC_ST_DONE) && (cnt_r == CW'(DONE_CYC - 1));
  wire tbase_hit = (state_r == MTC_ST_IDLE) && (cnt_r >= CW'(TBASE_CYCLES));
  wire ivl_hit   = (ivl_cnt_r == '0);
  wire idle_go   = (state_r == MTC_ST_IDLE) &&
                   ((!is_ext && tbase_hit) ||
                    (is_ext && (trig_evt || run_r)));

  // Armed means idle in an external mode, waiting for a trigger; continuous external mode disarms after its first.
  wire armed_nxt = (state_nxt == MTC_ST_IDLE) &&
                   (mode_nxt != MTC_MODE_CONT_INT) && !run_nxt;

  // Mode select by command; unknown codes leave the mode unchanged.
  always_comb
  begin
    mode_nxt = mode_r;
    if (mode_load && mode_sel == 2'h1)
      mode_nxt = MTC_MODE_CONT_EXT;
    else if (mode_load && mode_sel == 2'h2)
      mode_nxt = MTC_MODE_ONESHOT_EXT;
    else if (mode_load && mode_sel == 2'h0)
      mode_nxt = MTC_MODE_CONT_INT;
  end

  // Continuous external mode latches running after the first trigger.
  always_comb
  begin
    run_nxt = run_r;
    if (mode_load || !is_ext || is_oneshot)
      run_nxt = 1'b0;
    else if (trig_evt)
      run_nxt = 1'b1;
  end

  // Panel press in continuous external mode with store on starts a series.
  always_comb
  begin
    storing_nxt = storing_r;
    if (!store_en || mode_load || mode_r != MTC_MODE_CONT_EXT)
      storing_nxt = 1'b0;
    else if (pan_rise)
      storing_nxt = 1'b1;
  end

  always_comb
  begin
    ivl_cnt_nxt = ivl_cnt_r;
    if (!storing_r)
      ivl_cnt_nxt = '0;
    else if (conv_end)
      ivl_cnt_nxt = ivl_hit ? store_interval_cmd - 1'b1
                            : ivl_cnt_r - 1'b1;
  end

  always_comb
  begin
    wr_nxt = 1'b0;
    if (conv_end && store_en && is_oneshot)
      wr_nxt = 1'b1;
    else if (conv_end && storing_r && ivl_hit)
      wr_nxt = 1'b1;
  end

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 1'b1;
    case (state_r)
      MTC_ST_IDLE:
      begin
        if (idle_go)
        begin
          state_nxt = MTC_ST_CONV;
          cnt_nxt   = '0;
        end
        else if (tbase_hit)
          cnt_nxt = cnt_r;
      end
      MTC_ST_CONV:
      begin
        if (conv_end)
        begin
          state_nxt = MTC_ST_DONE;
          cnt_nxt   = '0;
        end
      end
      MTC_ST_DONE:
      begin
        if (done_end)
        begin
          state_nxt = MTC_ST_IDLE;
          cnt_nxt   = '0;
        end
      end
      default:
      begin
        state_nxt = MTC_ST_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      mode_r    <= MTC_MODE_CONT_INT;
      state_r   <= MTC_ST_IDLE;
      cnt_r     <= '0;
      run_r     <= 1'b0;
      storing_r <= 1'b0;
      ivl_cnt_r <= '0;
    end
    else
    begin
      mode_r    <= mode_nxt;
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      run_r     <= run_nxt;
      storing_r <= storing_nxt;
      ivl_cnt_r <= ivl_cnt_nxt;
    end
  end

  // Output flops; the completion pulse is low only in the done state.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      start_r  <= 1'b0;
      busy_r   <= 1'b0;
      wr_r     <= 1'b0;
      done_n_r <= 1'b1;
      armed_r  <= 1'b0;
    end
    else
    begin
      start_r  <= idle_go;
      busy_r   <= (state_nxt == MTC_ST_CONV);
      wr_r     <= wr_nxt;
      done_n_r <= (state_nxt != MTC_ST_DONE);
      armed_r  <= armed_nxt;
    end
  end

  assign conv_start = start_r;
  assign conv_busy  = busy_r;
  assign store_wr   = wr_r;
  assign complete_n = done_n_r;
  assign armed      = armed_r;
  assign mode_now   = mode_r;

  // Sequence checks on reading start, storage, the completion pulse and mode selection.
  done_after_conv_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) $fell(complete_n) |-> $past(conv_busy))
    else $error("Completion pulse without a finished conversion.");

  done_width_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) $fell(complete_n) |=> !complete_n)
    else $error("Completion pulse too short.");

  done_ends_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) $fell(complete_n) |-> ##[1:200] complete_n)
    else $error("Completion pulse never ended.");

  read_done_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) conv_start |-> ##CONV_CYCLES $fell(complete_n))
    else $error("Reading finished without a completion pulse.");

  busy_start_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) conv_start |-> conv_busy)
    else $error("Reading started without a busy conversion.");

  oneshot_single_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) (done_end && is_oneshot && !mode_load)
    ##1 !trig_evt |=> !conv_start)
    else $error("One-shot mode started an untriggered reading.");

  oneshot_hold_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) (armed && is_oneshot && !trig_evt)
    |=> !conv_start)
    else $error("Armed one-shot mode started without a trigger.");

  ext_trig_start_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) (state_r == MTC_ST_IDLE && is_ext && trig_evt)
    |=> conv_start)
    else $error("Accepted trigger did not start a reading.");

  panel_start_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) (state_r == MTC_ST_IDLE && is_oneshot && pan_rise)
    |=> conv_start)
    else $error("Panel press in one-shot mode did not start a reading.");

  cont_repeat_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) (done_end && run_r && !mode_load)
    |=> ##1 conv_start)
    else $error("Continuous series stopped.");

  store_oneshot_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) (conv_end && store_en && is_oneshot) |=> store_wr)
    else $error("One-shot reading was not stored.");

  store_cont_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) (conv_end && storing_r && ivl_hit) |=> store_wr)
    else $error("Interval reading was not stored.");

  int_pace_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) (conv_start && $past(mode_r == MTC_MODE_CONT_INT))
    |-> $past(tbase_hit))
    else $error("Internal mode reading not paced by time base.");

  mode_load_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) (mode_load && mode_sel == 2'h2)
    |=> mode_now == MTC_MODE_ONESHOT_EXT)
    else $error("One-shot external mode not selected.");

  // Main scenarios.
  cov_oneshot_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    is_oneshot && ext_fall ##[1:300] $fell(complete_n));
  cov_panel_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    is_oneshot && pan_rise ##[1:300] $fell(complete_n));
  cov_cont_c: cover property (@(posedge ref_clk) disable iff (!resetn)
    run_r && $fell(complete_n) ##[1:400] $fell(complete_n));
  cov_panel_store_c: cover property (@(posedge ref_clk) disable iff
    (!resetn) storing_r && store_wr);
endmodule : mtc_trigger_ctrl

// ==== tb/mtc_far_model.sv ====
// Far-side instrument: pulses the trigger pin and counts completion pulses.
`timescale 1ns/100ps
module mtc_far_model
(
  input  wire logic        ref_clk,
  input  wire logic        trig_req,
  input  wire logic        complete_n,
  output logic             ext_trig_n,
  output logic [31:0]      n_done
);
  logic [2:0]  low_cnt = 3'h0;
  logic        done_prev = 1'b1;
  logic [31:0] done_cnt = 32'h0;
  assign n_done = done_cnt;
  // A clean, debounced low pulse of five cycles; idle is the pulled-up high.
  assign ext_trig_n = (low_cnt != 3'h0) ? 1'b0 : 1'b1;
  always @(posedge ref_clk)
  begin
    if (trig_req)
      low_cnt <= 3'h5;
    else if (low_cnt != 3'h0)
      low_cnt <= low_cnt - 3'h1;
    if (done_prev === 1'b1 && complete_n === 1'b0)
      done_cnt <= done_cnt + 32'h1;
    done_prev <= complete_n;
  end
endmodule : mtc_far_model

// ==== tb/tb_measurement_trigger_control.sv ====
// Scenario testbench for the measurement trigger control block.
`timescale 1ns/100ps
module tb_measurement_trigger_control;
  import mtc_pkg::*;
  logic ref_clk = 0, resetn = 0, panel_trig = 0, mode_load = 0;
  logic store_en = 0, trig_req = 0, done_prev = 1;
  logic [1:0] mode_sel = 2'h0;
  logic [7:0] ivl = 8'h02;
  logic conv_start, conv_busy, store_wr, complete_n, armed, ext_trig_n;
  logic [1:0] mode_now;
  logic [31:0] n_done;
  int errors = 0, n_tests = 0, n_start = 0, n_store = 0, s, w, d;
  int s0, w0, d0;
  always #50 ref_clk = ~ref_clk;
  mtc_trigger_ctrl #(.CONV_CYCLES(4), .TBASE_CYCLES(8)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .ext_trig_n(ext_trig_n),
    .panel_trig(panel_trig), .mode_load(mode_load), .mode_sel(mode_sel),
    .store_en(store_en), .store_interval_cmd(ivl),
    .conv_start(conv_start), .conv_busy(conv_busy), .store_wr(store_wr),
    .complete_n(complete_n), .armed(armed), .mode_now(mode_now));
  mtc_far_model i_far (.ref_clk(ref_clk), .trig_req(trig_req),
    .complete_n(complete_n), .ext_trig_n(ext_trig_n), .n_done(n_done));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  always @(posedge ref_clk)
  begin
    if (resetn && conv_start === 1'b1)
      n_start++;
    if (resetn && store_wr === 1'b1)
      n_store++;
    if (resetn && done_prev === 1'b1 && complete_n === 1'b0)
      check(conv_busy, 0);
    done_prev <= complete_n;
  end
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cycles
  task wait_armed;
    int k;
    for (k = 0; k < 1000 && armed !== 1'b1; k++)
      cycles(1);
    if (k == 1000)
    begin
      errors++;
      print_verdict;
    end
  endtask : wait_armed
  task set_mode(input logic [1:0] m);
    @(negedge ref_clk) mode_sel = m;
    mode_load = 1;
    cycles(1);
    mode_load = 0;
    cycles(2);
    check(mode_now, m);
  endtask : set_mode
  task snap;
    s0 = n_start;
    w0 = n_store;
    d0 = n_done;
  endtask : snap
  task diff(input int n);
    cycles(n);
    s = n_start - s0;
    w = n_store - w0;
    d = n_done - d0;
  endtask : diff
  task measure(input int n);
    snap;
    diff(n);
  endtask : measure
  task press;
    panel_trig = 1;
    cycles(2);
    panel_trig = 0;
  endtask : press
  task pin_pulse;
    trig_req = 1;
    cycles(1);
    trig_req = 0;
  endtask : pin_pulse
  task t_powerup;
    check(mode_now, 0);
    check(complete_n, 1);
    check(armed, 0);
    measure(400);
    check(s >= 2, 1);
    check(d >= 1, 1);
  endtask : t_powerup
  task t_oneshot_pin;
    set_mode(2'h2);
    wait_armed;
    store_en = 1;
    snap;
    pin_pulse;
    cycles(30);
    pin_pulse;
    diff(300);
    check(s, 1);
    check(d, 1);
    check(w, 1);
    check(armed, 1);
    pin_pulse;
    diff(300);
    check(s, 2);
    check(d, 2);
    check(w, 2);
  endtask : t_oneshot_pin
  task t_oneshot_panel;
    store_en = 0;
    snap;
    press;
    diff(300);
    check(s, 1);
    check(w, 0);
    check(d, 1);
  endtask : t_oneshot_panel
  task t_cont_pin;
    set_mode(2'h1);
    wait_armed;
    snap;
    pin_pulse;
    diff(430);
    check(s >= 3, 1);
    check(d >= 3, 1);
  endtask : t_cont_pin
  task t_cont_store;
    set_mode(2'h1);
    wait_armed;
    store_en = 1;
    snap;
    press;
    diff(640);
    check(s >= 5, 1);
    check(w >= s / 2 && w <= (s + 1) / 2 && w >= 2, 1);
  endtask : t_cont_store
  task t_back_int;
    store_en = 0;
    set_mode(2'h0);
    measure(300);
    check(s >= 2, 1);
    check(armed, 0);
  endtask : t_back_int
  initial
  begin
    cycles(6);
    resetn = 1;
    cycles(1);
    t_powerup;
    t_oneshot_pin;
    t_oneshot_panel;
    t_cont_pin;
    t_cont_store;
    t_back_int;
    print_verdict;
  end
endmodule : tb_measurement_trigger_control
